/* File: ccrb_top.sv */
// ccrb_top: chip control register bank with host register port, standby
// controls, PLL settings, version readback and page select.
// Assumes the host port front end runs on sys_clk and issues one-cycle strobes.
// Function
// - writes outside the map change nothing
// - bit 7 enables digital audio path
// - bit 6 gates synthesizer PLL clock
// - bit 5 gates audio PLL clock
// - bit 4 enables serial receive
// - bit 3 enables serial transmit
// - serial clocks sleep only when both off
// - bit 2 enables sound synthesizer
// - bit 1 enables audio DAC
// - bit 0 supplies analog reference
// - PLL settings reset 1c 80 02 2a
// - read-only version, readable in serial mode
// - master standby drives clocks low, output floats
`timescale 1ns/1ps
`default_nettype none
module ccrb_top
  import ccrb_pkg::*;
#(
  parameter logic [3:0] VERSION_UPPER = 4'h5,  // fixed upper nibble, value arbitrary
  parameter logic [3:0] VERSION_FIELD = 4'h1   // version_field, value arbitrary
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // host register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       serial_mode_pin,
  // standby controls
  output logic            digital_path_enable,
  output logic            synth_pll_enable,
  output logic            audio_pll_enable,
  output logic            serial_rx_enable,
  output logic            serial_tx_enable,
  output logic            synth_enable,
  output logic            dac_enable,
  output logic            analog_reference_enable,
  // settings for neighbouring blocks
  output logic      [7:0] audio_pll_setting_a,
  output logic      [7:0] audio_pll_setting_b,
  output logic      [7:0] synth_pll_setting_a,
  output logic      [7:0] synth_pll_setting_b,
  output logic      [1:0] page_select,
  output logic            audio_port_master_select,
  // audio serial clock pins
  input  wire logic       bclk_pin_i,
  input  wire logic       lrclk_pin_i,
  input  wire logic       bclk_gen,
  input  wire logic       lrclk_gen,
  output logic            bclk_pin_o,
  output logic            bclk_pin_oe,
  output logic            lrclk_pin_o,
  output logic            lrclk_pin_oe,
  output logic            aso_pin_oe,
  output logic            bclk_int,
  output logic            lrclk_int
);

  // whole state of the bank
  typedef struct packed {
    logic [CCRB_NREG-1:0][7:0] regs;  // locations 00h..22h, masked bits only
    logic [7:0]                page;  // page_select
    logic [7:0]                rdata; // read data holding register
    logic [2:0]                sync1; // first stage: serial mode, bclk, lrclk
    logic [2:0]                sync2; // second stage, the only one logic reads
  } ccrb_state_s;

  ccrb_state_s st_reg;   // registered state
  ccrb_state_s st_next;  // next state

  ccrb_pwr_if pif ();    // link to the standby decoder

  logic [7:0] wmask;     // writable bits of the addressed location
  logic       in_array;  // address falls in the indexed range
  logic       serial_mode; // synchronised host port mode
  logic [7:0] rd_value;  // value of the addressed location
  logic [5:0] idx;       // array index of the address

  // address decode shared by read and write
  always_comb begin
    wmask       = ccrb_wmask(reg_addr);
    in_array    = (reg_addr < 7'(CCRB_NREG));
    idx         = reg_addr[5:0];
    serial_mode = st_reg.sync2[2];
  end

  // read multiplexer; unmapped and reserved locations read zero
  always_comb begin
    rd_value = 8'h00;
    if (reg_addr == CCRB_CHIP_VERSION) begin
      // version only reachable over the serial host port
      rd_value = serial_mode ? {VERSION_UPPER, VERSION_FIELD} : 8'h00;
    end else if (reg_addr == CCRB_PAGE_SELECT) begin
      rd_value = st_reg.page;
    end else if (in_array) begin
      // stored bits are already masked, so fixed-zero bits read zero
      rd_value = st_reg.regs[idx];
    end
  end

  // next-state logic
  always_comb begin
    st_next = st_reg;
    if (sys_rst) begin
      // every writable location back to its initial value
      for (int i = 0; i < CCRB_NREG; i++) begin
        st_next.regs[i] = ccrb_rst(7'(i));
      end
      st_next.page  = CCRB_PAGE_RESET;
      st_next.rdata = 8'h00;
      st_next.sync1 = 3'h0;
      st_next.sync2 = 3'h0;
    end else if (clk_en) begin
      // pins pass two flops; first stage feeds only the second
      st_next.sync1 = {serial_mode_pin, bclk_pin_i, lrclk_pin_i};
      st_next.sync2 = st_reg.sync1;
      // registered read data, one cycle after the strobe
      if (reg_rd) begin
        st_next.rdata = rd_value;
      end
      // writes land only on writable bits; all else ignored
      if (reg_wr) begin
        if (reg_addr == CCRB_PAGE_SELECT) begin
          st_next.page = reg_wdata & CCRB_PAGE_MASK;
        end else if (in_array && wmask != 8'h00) begin
          // read-only version and reserved slots have zero mask
          st_next.regs[idx] = reg_wdata & wmask;
        end
      end
    end
  end

  // state register; reset is synchronous, handled in the next-state logic
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  // feed the standby decoder
  always_comb begin
    pif.pwr_ctrl  = st_reg.regs[CCRB_POWER_STATE_CTRL];
    pif.master    = st_reg.regs[CCRB_AUDIO_PORT_CONFIG][CCRB_MASTER_SELECT_BIT];
    pif.bclk_in   = st_reg.sync2[1];
    pif.lrclk_in  = st_reg.sync2[0];
    pif.bclk_gen  = bclk_gen;
    pif.lrclk_gen = lrclk_gen;
  end

  ccrb_power_decode u_dec (
    .p (pif.dec)
  );

  // standby outputs straight from stored bits
  always_comb begin
    digital_path_enable     = st_reg.regs[0][CCRB_DIGITAL_PATH_BIT];
    synth_pll_enable        = st_reg.regs[0][CCRB_SYNTH_PLL_BIT];
    audio_pll_enable        = st_reg.regs[0][CCRB_AUDIO_PLL_BIT];
    serial_rx_enable        = st_reg.regs[0][CCRB_SERIAL_RX_BIT];
    serial_tx_enable        = st_reg.regs[0][CCRB_SERIAL_TX_BIT];
    synth_enable            = st_reg.regs[0][CCRB_SYNTH_BIT];
    dac_enable              = st_reg.regs[0][CCRB_DAC_BIT];
    // host must keep this on; nothing analog works without it
    analog_reference_enable = st_reg.regs[0][CCRB_ANALOG_REF_BIT];
  end

  // settings and pin outputs
  always_comb begin
    audio_pll_setting_a      = st_reg.regs[CCRB_AUDIO_PLL_A];
    audio_pll_setting_b      = st_reg.regs[CCRB_AUDIO_PLL_B];
    synth_pll_setting_a      = st_reg.regs[CCRB_SYNTH_PLL_A];
    synth_pll_setting_b      = st_reg.regs[CCRB_SYNTH_PLL_B];
    page_select              = st_reg.page[1:0];
    audio_port_master_select = pif.master;
    reg_rdata                = st_reg.rdata;
    bclk_pin_o               = pif.bclk_o;
    bclk_pin_oe              = pif.bclk_oe;
    lrclk_pin_o              = pif.lrclk_o;
    lrclk_pin_oe             = pif.lrclk_oe;
    aso_pin_oe               = pif.aso_oe;
    bclk_int                 = pif.bclk_int;
    lrclk_int                = pif.lrclk_int;
  end

  // checks, all on sys_clk and quiet during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic unmapped_wr; // write that must leave the bank untouched
  assign unmapped_wr = reg_wr && clk_en && (reg_addr != CCRB_PAGE_SELECT) && (!in_array || wmask == 8'h00);

  unmapped_write_a: assert property (unmapped_wr |=> $stable(st_reg.regs) && $stable(st_reg.page))
    else $error("write outside map changed state");

  digital_reset_a: assert property ($past(sys_rst) |-> !digital_path_enable && !analog_reference_enable)
    else $error("power bits not cleared by reset");

  pll_gate_a: assert property (reg_wr && clk_en && reg_addr == CCRB_POWER_STATE_CTRL
    |=> synth_pll_enable == $past(reg_wdata[6]) && audio_pll_enable == $past(reg_wdata[5]))
    else $error("pll enables do not follow write");

  block_enables_a: assert property (reg_wr && clk_en && reg_addr == CCRB_POWER_STATE_CTRL
    |=> {synth_enable, dac_enable, digital_path_enable} == {$past(reg_wdata[2]), $past(reg_wdata[1]),
        $past(reg_wdata[7])})
    else $error("block enables do not follow write");

  clocks_active_a: assert property (pif.master && (serial_rx_enable || serial_tx_enable)
    |-> bclk_pin_o == bclk_gen && lrclk_pin_o == lrclk_gen && bclk_pin_oe)
    else $error("serial clocks stopped while a direction runs");

  master_low_a: assert property (pif.master && !serial_rx_enable && !serial_tx_enable
    |-> !bclk_pin_o && !lrclk_pin_o && bclk_pin_oe && lrclk_pin_oe)
    else $error("master standby clocks not driven low");

  slave_input_a: assert property (!pif.master |-> !bclk_pin_oe && !lrclk_pin_oe &&
    (bclk_int == (st_reg.sync2[1] && (serial_rx_enable || serial_tx_enable))))
    else $error("slave clock pins driven or internal clock wrong");

  aso_float_a: assert property (aso_pin_oe == serial_tx_enable)
    else $error("serial output drive does not follow transmit enable");

  pll_reset_a: assert property ($past(sys_rst) |-> audio_pll_setting_a == 8'h1c && audio_pll_setting_b == 8'h80
    && synth_pll_setting_a == 8'h02 && synth_pll_setting_b == 8'h2a)
    else $error("pll settings wrong after reset");

  version_read_a: assert property (reg_rd && clk_en && reg_addr == CCRB_CHIP_VERSION
    |=> reg_rdata == ($past(serial_mode) ? {VERSION_UPPER, VERSION_FIELD} : 8'h00))
    else $error("version readback wrong");

  reserved_read_a: assert property (reg_rd && clk_en && reg_addr == 7'h06 ##1 !reg_wr [*2]
    |-> reg_rdata == 8'h00)
    else $error("reserved location holds state");

  ref_follow_a: assert property (reg_wr && clk_en && reg_addr == CCRB_POWER_STATE_CTRL
    ##1 (!reg_wr) [*3] |-> analog_reference_enable == $past(reg_wdata[0], 3))
    else $error("reference enable lost");

  cover_power_on_c: cover property (reg_wr && reg_addr == CCRB_POWER_STATE_CTRL && reg_wdata == 8'hff);
  cover_version_c: cover property (reg_rd && reg_addr == CCRB_CHIP_VERSION && serial_mode);
  cover_master_sleep_c: cover property (pif.master && !serial_rx_enable && !serial_tx_enable);

endmodule
`default_nettype wire

/* File: ccrb_pkg.sv */
// ccrb_pkg: offsets, field positions, reset values and write masks of the
// chip control register bank. It assumes an 8-bit register map with a 7-bit address.
package ccrb_pkg;

  localparam int unsigned CCRB_AW   = 7;   // register address width
  localparam int unsigned CCRB_DW   = 8;   // register data width
  localparam int unsigned CCRB_NREG = 35;  // directly indexed locations 00h..22h

  // register offsets
  localparam logic [6:0] CCRB_POWER_STATE_CTRL   = 7'h00;
  localparam logic [6:0] CCRB_AUDIO_PLL_A        = 7'h01;
  localparam logic [6:0] CCRB_AUDIO_PLL_B        = 7'h02;
  localparam logic [6:0] CCRB_SYNTH_PLL_A        = 7'h03;
  localparam logic [6:0] CCRB_SYNTH_PLL_B        = 7'h04;
  localparam logic [6:0] CCRB_CLOCK_INPUT_SELECT = 7'h05;
  localparam logic [6:0] CCRB_SERIAL_RATE_SELECT = 7'h07;
  localparam logic [6:0] CCRB_AUDIO_PORT_CONFIG  = 7'h08;
  localparam logic [6:0] CCRB_INPUT_MIX_PATHS    = 7'h09;
  localparam logic [6:0] CCRB_SYNTH_MIX_PATHS    = 7'h0a;
  localparam logic [6:0] CCRB_SURROUND_SELECT    = 7'h0b;
  localparam logic [6:0] CCRB_INDICATOR_OUTPUTS  = 7'h0d;
  localparam logic [6:0] CCRB_GENERAL_OUTPUT     = 7'h0e;
  localparam logic [6:0] CCRB_SOFT_MUTE_CTRL     = 7'h10;
  localparam logic [6:0] CCRB_SYNTH_LEFT_GAIN    = 7'h11;
  localparam logic [6:0] CCRB_SYNTH_RIGHT_GAIN   = 7'h12;
  localparam logic [6:0] CCRB_SERIAL_LEFT_GAIN   = 7'h13;
  localparam logic [6:0] CCRB_SERIAL_RIGHT_GAIN  = 7'h14;
  localparam logic [6:0] CCRB_LEFT_ANALOG_GAIN   = 7'h17;
  localparam logic [6:0] CCRB_RIGHT_ANALOG_GAIN  = 7'h18;
  localparam logic [6:0] CCRB_SYNTH_PORT_POWER   = 7'h20;
  localparam logic [6:0] CCRB_SYNTH_PORT_CONFIG  = 7'h21;
  localparam logic [6:0] CCRB_SYNTH_PORT_CHANNEL = 7'h22;
  localparam logic [6:0] CCRB_CHIP_VERSION       = 7'h3f;
  localparam logic [6:0] CCRB_PAGE_SELECT        = 7'h7c;

  // power_state_ctrl field positions
  localparam int unsigned CCRB_DIGITAL_PATH_BIT = 7;
  localparam int unsigned CCRB_SYNTH_PLL_BIT    = 6;
  localparam int unsigned CCRB_AUDIO_PLL_BIT    = 5;
  localparam int unsigned CCRB_SERIAL_RX_BIT    = 4;
  localparam int unsigned CCRB_SERIAL_TX_BIT    = 3;
  localparam int unsigned CCRB_SYNTH_BIT        = 2;
  localparam int unsigned CCRB_DAC_BIT          = 1;
  localparam int unsigned CCRB_ANALOG_REF_BIT   = 0;
  // audio_port_config: audio_port_master_select position
  localparam int unsigned CCRB_MASTER_SELECT_BIT = 2;

  // page_select write mask and reset
  localparam logic [7:0] CCRB_PAGE_MASK  = 8'h03;
  localparam logic [7:0] CCRB_PAGE_RESET = 8'h00;

  // writable bits per location; zero for reserved, unmapped and read-only locations and for page_select, masked apart
  function automatic logic [7:0] ccrb_wmask(input logic [6:0] a);
    case (a)
      7'h00, 7'h02, 7'h04, 7'h07, 7'h09, 7'h0a, 7'h11, 7'h12, 7'h13, 7'h14, 7'h22: ccrb_wmask = 8'hff;
      7'h01, 7'h21: ccrb_wmask = 8'h7f;
      7'h03, 7'h17, 7'h18: ccrb_wmask = 8'h1f;
      7'h05, 7'h0d, 7'h20: ccrb_wmask = 8'h03;
      7'h08: ccrb_wmask = 8'h3f;
      7'h0b: ccrb_wmask = 8'h05;
      7'h0e, 7'h10: ccrb_wmask = 8'h0f;
      default: ccrb_wmask = 8'h00;
    endcase
  endfunction

  // initial value per location
  function automatic logic [7:0] ccrb_rst(input logic [6:0] a);
    case (a)
      7'h01: ccrb_rst = 8'h1c;
      7'h02: ccrb_rst = 8'h80;
      7'h03: ccrb_rst = 8'h02;
      7'h04: ccrb_rst = 8'h2a;
      7'h09, 7'h0a: ccrb_rst = 8'hf0;
      7'h11, 7'h12, 7'h13, 7'h14: ccrb_rst = 8'hff;
      7'h17, 7'h18: ccrb_rst = 8'h1f;
      7'h21: ccrb_rst = 8'h10;
      7'h22: ccrb_rst = 8'h33;
      default: ccrb_rst = 8'h00;
    endcase
  endfunction

endpackage

/* File: ccrb_pwr_if.sv */
// ccrb_pwr_if: carries the power control byte and serial clock signals
// between the register bank and its standby decoder; all on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface ccrb_pwr_if;
  logic [7:0] pwr_ctrl;      // power_state_ctrl contents
  logic       master;        // audio_port_master_select
  logic       bclk_in;       // synchronised bit clock pin
  logic       lrclk_in;      // synchronised frame clock pin
  logic       bclk_gen;      // internally generated bit clock
  logic       lrclk_gen;     // internally generated frame clock
  logic       serial_active; // either serial direction running
  logic       bclk_o;        // bit clock pin value
  logic       bclk_oe;       // bit clock pin enable
  logic       lrclk_o;       // frame clock pin value
  logic       lrclk_oe;      // frame clock pin enable
  logic       aso_oe;        // serial output pin enable
  logic       bclk_int;      // bit clock seen by the port logic
  logic       lrclk_int;     // frame clock seen by the port logic

  modport bank (output pwr_ctrl, master, bclk_in, lrclk_in, bclk_gen, lrclk_gen,
                input serial_active, bclk_o, bclk_oe, lrclk_o, lrclk_oe, aso_oe, bclk_int, lrclk_int);
  modport dec  (input pwr_ctrl, master, bclk_in, lrclk_in, bclk_gen, lrclk_gen,
                output serial_active, bclk_o, bclk_oe, lrclk_o, lrclk_oe, aso_oe, bclk_int, lrclk_int);
endinterface
`default_nettype wire

/* File: ccrb_power_decode.sv */
// ccrb_power_decode: turns the serial standby bits and master select into
// pin drive and internal clock levels. Purely combinational; the bank holds state.
`timescale 1ns/1ps
`default_nettype none
module ccrb_power_decode
  import ccrb_pkg::*;
(
  ccrb_pwr_if.dec p
);

  // pin and internal clock decode
  always_comb begin
    // clocks keep running while either direction is out of standby
    p.serial_active = p.pwr_ctrl[CCRB_SERIAL_RX_BIT] | p.pwr_ctrl[CCRB_SERIAL_TX_BIT];
    if (p.master) begin
      // master drives the clocks, low when both directions sleep
      p.bclk_oe   = 1'b1;
      p.lrclk_oe  = 1'b1;
      p.bclk_o    = p.serial_active & p.bclk_gen;
      p.lrclk_o   = p.serial_active & p.lrclk_gen;
      p.bclk_int  = p.bclk_o;
      p.lrclk_int = p.lrclk_o;
    end else begin
      // slave keeps pins as inputs; internal copy forced low in standby
      p.bclk_oe   = 1'b0;
      p.lrclk_oe  = 1'b0;
      p.bclk_o    = 1'b0;
      p.lrclk_o   = 1'b0;
      p.bclk_int  = p.serial_active & p.bclk_in;
      p.lrclk_int = p.serial_active & p.lrclk_in;
    end
    // serial output floats whenever transmit is in standby
    p.aso_oe = p.pwr_ctrl[CCRB_SERIAL_TX_BIT];
  end

endmodule
`default_nettype wire

/* File: ccrb_host_model.sv */
// ccrb_host_model: behavioural host on the register strobe port.
// assumes one sys_clk domain and one-cycle strobes, as the bank expects.
`timescale 1ns/1ps
`default_nettype none
module ccrb_host_model (
  input  wire logic       sys_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  // one write; address and data flip after release so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // one read; data is taken once the accepting edge has settled
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: chip_control_register_bank_tb.sv */
// chip_control_register_bank_tb: self-checking bench with a register model.
// assumes ccrb_pkg, ccrb_pwr_if, ccrb_power_decode, ccrb_top and the host model.
`timescale 1ns/1ps
`default_nettype none
module chip_control_register_bank_tb;
  import ccrb_pkg::*;
  localparam logic [3:0] VER_HI = 4'h6;   // arbitrary value
  localparam logic [3:0] VER_LO = 4'h3;   // arbitrary value
  logic       sys_clk, sys_rst, clk_en, ser;
  logic       bpin, lpin, bgen, lgen;
  wire logic  reg_wr, reg_rd;
  wire logic [6:0] reg_addr;
  wire logic [7:0] reg_wdata, reg_rdata, apa, apb, spa, spb, en;
  wire logic [1:0] page_select;
  wire logic  master, bo, boe, lo, loe, aoe, bint, lint;
  logic [7:0] mdl [128];                  // register model
  int         n_fail, comparisons, seed;
  logic [7:0] d, e;

  ccrb_host_model host_i (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  ccrb_top #(.VERSION_UPPER(VER_HI), .VERSION_FIELD(VER_LO)) ccrb_top_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_mode_pin(ser), .digital_path_enable(en[7]),
    .synth_pll_enable(en[6]), .audio_pll_enable(en[5]), .serial_rx_enable(en[4]),
    .serial_tx_enable(en[3]), .synth_enable(en[2]), .dac_enable(en[1]), .analog_reference_enable(en[0]),
    .audio_pll_setting_a(apa), .audio_pll_setting_b(apb), .synth_pll_setting_a(spa),
    .synth_pll_setting_b(spb), .page_select(page_select), .audio_port_master_select(master),
    .bclk_pin_i(bpin), .lrclk_pin_i(lpin), .bclk_gen(bgen), .lrclk_gen(lgen), .bclk_pin_o(bo),
    .bclk_pin_oe(boe), .lrclk_pin_o(lo), .lrclk_pin_oe(loe), .aso_pin_oe(aoe), .bclk_int(bint),
    .lrclk_int(lint));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // writable bits per location, taken from the fixed-zero columns of the map
  function automatic logic [7:0] emask(input int a);
    case (a)
      'h00, 'h02, 'h04, 'h07, 'h09, 'h0a, 'h11, 'h12, 'h13, 'h14, 'h22: return 8'hff;
      'h01, 'h21: return 8'h7f;
      'h03, 'h17, 'h18: return 8'h1f;
      'h05, 'h0d, 'h20, 'h7c: return 8'h03;
      'h08: return 8'h3f;
      'h0b: return 8'h05;
      'h0e, 'h10: return 8'h0f;
      default: return 8'h00;             // reserved, unmapped or read-only
    endcase
  endfunction

  // initial values of the map
  function automatic logic [7:0] erst(input int a);
    case (a)
      'h01: return 8'h1c;
      'h02: return 8'h80;
      'h03: return 8'h02;
      'h04: return 8'h2a;
      'h09, 'h0a: return 8'hf0;
      'h11, 'h12, 'h13, 'h14: return 8'hff;
      'h17, 'h18: return 8'h1f;
      'h21: return 8'h10;
      'h22: return 8'h33;
      default: return 8'h00;
    endcase
  endfunction

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // model update for a host write; refused places keep nothing
  task automatic mwr(input int a, input logic [7:0] v);
    host_i.wr(7'(a), v);
    mdl[a] = v & emask(a);
    #1;
    chk(en, mdl[0]);
    chk(apa, mdl[1]);
    chk(apb, mdl[2]);
    chk(spa, mdl[3]);
    chk(spb, mdl[4]);
    chk({4'h0, aoe, master, page_select}, {4'h0, mdl[0][3], mdl[8][2], mdl['h7c][1:0]});
  endtask

  // read the whole map and compare each location
  task automatic check_all();
    for (int a = 0; a < 128; a++) begin
      host_i.rd(7'(a), d);
      e = (a == 'h3f) ? (ser ? {VER_HI, VER_LO} : 8'h00) : mdl[a];
      chk(d, e);
    end
  endtask

  task automatic reset_dut();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 128; a++) mdl[a] = erst(a);
  endtask

  task automatic finish_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog well beyond the expected 1400 or so cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    {sys_rst, clk_en, ser, bpin, lpin, bgen, lgen} = 7'b1100000;
    n_fail = 0;
    comparisons = 0;
    seed = 55575;
    reset_dut();
    check_all();
    // random bytes at every address, reserved and read-only ones too
    for (int a = 0; a < 128; a++) mwr(a, 8'($random(seed)));
    check_all();
    // one power bit at a time
    for (int b = 0; b < 8; b++) mwr(0, 8'h01 << b);
    // serial clocks for both port modes and all standby pairs, reference kept on
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        mwr(8, 8'(m << 2));
        mwr(0, {3'b000, 2'(s), 3'b001});
        d = 8'($random(seed));
        @(posedge sys_clk);
        {bpin, lpin, bgen, lgen} <= d[3:0];
        repeat (4) @(posedge sys_clk);
        #1;
        e[6:5] = (m == 1 && s != 0) ? d[1:0] : 2'b00;
        e[4:3] = {2{m[0]}};
        e[2]   = s[0];
        e[1:0] = (m == 1) ? e[6:5] : (d[3:2] & {2{s != 0}});
        chk({1'b0, bo, lo, boe, loe, aoe, bint, lint}, {1'b0, e[6:0]});
      end
    end
    // frozen bank ignores a write
    @(posedge sys_clk);
    clk_en <= 1'b0;
    host_i.wr(7'h01, 8'h55);
    clk_en <= 1'b1;
    // version readable once serial mode has synchronised
    ser <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check_all();
    // second reset in mid-run restores every initial value
    reset_dut();
    check_all();
    finish_test();
  end
endmodule
`default_nettype wire
